// file: inc/ppe_pkg.sv
// Purpose: Shared constants and types for the pin event control block
// Assumes: 32-bit AHB-Lite register bus, byte offsets decoded on the low 12 bits
// Notes: Three output units, two capture units, two shared pins
package ppe_pkg;
    localparam int NUM_OUT = 3;
    localparam int NUM_CAP = 2;
    localparam int NUM_PIN = 2;

    // Register byte offsets
    localparam logic [11:0] OFF_UNIT_CTRL = 12'h52C;
    localparam logic [11:0] OFF_TGT_NS = 12'h530;
    localparam logic [11:0] OFF_TGT_S = 12'h534;
    localparam logic [11:0] OFF_OUT_CFG = 12'h538;
    localparam logic [11:0] OFF_INDEX = 12'h540;
    localparam logic [11:0] OFF_IRQ_STS = 12'h544;
    localparam logic [11:0] OFF_IRQ_CLR = 12'h548;
    localparam logic [11:0] OFF_IRQ_EN = 12'h54C;
    localparam logic [11:0] OFF_CAP_STS = 12'h550;

    // Unit control/status word bit positions
    localparam int B_OUT_SRC = 8;
    localparam int B_PIN_LVL = 7;
    localparam int B_PIN_DIR = 6;
    localparam int B_CAP_IRQ = 5;
    localparam int B_OUT_ACT = 4;
    localparam int B_OUT_EN = 3;
    localparam int B_OUT_CLR = 2;
    localparam int B_CAP_ON = 1;
    localparam int B_CAP_CLR = 0;

    // Index register fields
    localparam int IDX_OUT_LSB = 0;
    localparam int IDX_CAP_BIT = 8;
    localparam int IDX_PIN_BIT = 16;

    // Output configuration and capture status fields
    localparam int B_NOTIFY = 24;
    localparam int B_CAP_RDY = 8;
    localparam int B_CAP_OVF = 9;

    // Interrupt status layout
    localparam int IRQ_DONE_LSB = 0;
    localparam int IRQ_FAULT_LSB = 3;
    localparam int IRQ_CAP_LSB = 6;
    localparam int IRQ_W = 8;

    // Reset values and capture count limit
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [7:0] RST_CNT = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;

    // Pointers held in the index register
    typedef struct packed {
        logic pin;
        logic cap;
        logic [1:0] out;
    } ppe_idx_t;

    // Latched AHB address phase
    typedef struct packed {
        logic wr;
        logic [11:0] addr;
    } ppe_aphase_t;
endpackage

// file: src/ppe_top.sv
// Purpose: Control and status for time-synchronised pin event units
// Assumes: Synchronised time arrives on the same clock; pins are asynchronous
// Notes: Zero wait-state AHB-Lite slave, response always OKAY
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
module ppe_top (
    input wire logic i_ref_clk,               // System clock, 25 MHz
    input wire logic i_resetn,                // Asynchronous reset, active low
    input wire logic i_clk_en,                // Freezes all state while low
    input wire logic i_hsel,                  // AHB slave select
    input wire logic [31:0] i_haddr,          // AHB address
    input wire logic [1:0] i_htrans,          // AHB transfer type
    input wire logic i_hwrite,                // AHB write
    input wire logic [2:0] i_hsize,           // AHB size, word only
    input wire logic [31:0] i_hwdata,         // AHB write data
    input wire logic i_hready,                // AHB bus ready
    output logic [31:0] o_hrdata,             // AHB read data
    output logic o_hreadyout,                 // AHB slave ready
    output logic o_hresp,                     // AHB response, always OKAY
    input wire logic [31:0] i_sync_sec,       // Synchronised time, seconds
    input wire logic [29:0] i_sync_ns,        // Synchronised time, nanoseconds
    input wire logic [ppe_pkg::NUM_PIN-1:0] i_pin_in,   // Pin input levels
    output logic [ppe_pkg::NUM_PIN-1:0] o_pin_out,      // Pin output levels
    output logic [ppe_pkg::NUM_PIN-1:0] o_pin_oe_n,     // Pin drive enable, low drives
    output logic o_irq                        // Level interrupt
);
    import ppe_pkg::*;

    // Bus group state
    ppe_aphase_t aph_reg, aph_next;
    logic wpend_reg, wpend_next;
    logic [31:0] rdata_reg, rdata_next;

    // Unit group state
    ppe_idx_t idx_reg, idx_next;
    logic [NUM_OUT-1:0] out_en_reg, out_en_next;
    logic [NUM_OUT-1:0] out_clr_reg, out_clr_next;
    logic [NUM_OUT-1:0] fault_reg, fault_next;
    logic [NUM_OUT-1:0] notify_reg, notify_next;
    logic [NUM_OUT-1:0] fire_q_reg, fire_q_next;
    logic [29:0] tgt_ns_reg [NUM_OUT], tgt_ns_next [NUM_OUT];
    logic [31:0] tgt_s_reg [NUM_OUT], tgt_s_next [NUM_OUT];
    logic [NUM_PIN-1:0] out_src_reg, out_src_next;
    logic [NUM_PIN-1:0] dir_reg, dir_next;
    logic [NUM_CAP-1:0] cap_ie_reg, cap_ie_next;
    logic [NUM_CAP-1:0] cap_on_reg, cap_on_next;
    logic [NUM_CAP-1:0] cap_clr_reg, cap_clr_next;
    logic [NUM_CAP-1:0] rdy_reg, rdy_next;
    logic [NUM_CAP-1:0] ovf_reg, ovf_next;
    logic [7:0] cnt_reg [NUM_CAP], cnt_next [NUM_CAP];
    logic [IRQ_W-1:0] sts_reg, sts_next;
    logic [IRQ_W-1:0] ien_reg, ien_next;

    // Pin synchronisers and edge history
    logic [NUM_PIN-1:0] pin_s1_reg, pin_s2_reg, pin_prev_reg;

    logic [NUM_OUT-1:0] fire;
    logic [NUM_OUT-1:0] past;
    logic [61:0] now_time;

    // Address decode shared by read and write paths
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    assign now_time = {i_sync_sec, i_sync_ns};

    generate
        for (genvar u = 0; u < NUM_OUT; u++) begin : g_cmp
            assign past[u] = {tgt_s_reg[u], tgt_ns_reg[u]} < now_time;
            assign fire[u] = out_en_reg[u] & ~fault_reg[u] &
                             ({tgt_s_reg[u], tgt_ns_reg[u]} <= now_time);
        end
    endgenerate

    // Two-flop synchronisers on the pins, then an edge history flop
    generate
        for (genvar p = 0; p < NUM_PIN; p++) begin : g_sync
            always_ff @(posedge i_ref_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    pin_s1_reg[p] <= 1'b0;
                    pin_s2_reg[p] <= 1'b0;
                    pin_prev_reg[p] <= 1'b0;
                end else if (i_clk_en) begin
                    pin_s1_reg[p] <= i_pin_in[p];
                    pin_s2_reg[p] <= pin_s1_reg[p];
                    pin_prev_reg[p] <= pin_s2_reg[p];
                end
            end
        end
    endgenerate

    // Bus group: address phase latch and read data
    always_comb begin
        logic [11:0] a;
        logic [1:0] po;
        a = i_haddr[11:0];
        po = idx_reg.out;
        aph_next = aph_reg;
        wpend_next = 1'b0;
        rdata_next = rdata_reg;
        if (i_hsel && i_htrans[1] && i_hready) begin
            aph_next.addr = a;
            aph_next.wr = i_hwrite;
            wpend_next = i_hwrite;
            rdata_next = RST_WORD;
            if (!i_hwrite) begin
                if (hit(a, OFF_UNIT_CTRL)) begin
                    rdata_next[B_OUT_SRC] = out_src_reg[idx_reg.pin];
                    rdata_next[B_PIN_LVL] = pin_s2_reg[idx_reg.pin];
                    rdata_next[B_PIN_DIR] = dir_reg[idx_reg.pin];
                    rdata_next[B_CAP_IRQ] = cap_ie_reg[idx_reg.cap];
                    rdata_next[B_CAP_ON] = cap_on_reg[idx_reg.cap];
                    rdata_next[B_CAP_CLR] = cap_clr_reg[idx_reg.cap];
                    if (po < 2'(NUM_OUT)) begin
                        rdata_next[B_OUT_ACT] = out_en_reg[po] & ~fault_reg[po];
                        rdata_next[B_OUT_EN] = out_en_reg[po];
                        rdata_next[B_OUT_CLR] = out_clr_reg[po];
                    end
                end else if (hit(a, OFF_TGT_NS) && po < 2'(NUM_OUT)) begin
                    rdata_next = {2'b00, tgt_ns_reg[po]};
                end else if (hit(a, OFF_TGT_S) && po < 2'(NUM_OUT)) begin
                    rdata_next = tgt_s_reg[po];
                end else if (hit(a, OFF_OUT_CFG) && po < 2'(NUM_OUT)) begin
                    rdata_next[B_NOTIFY] = notify_reg[po];
                end else if (hit(a, OFF_INDEX)) begin
                    rdata_next[IDX_OUT_LSB +: 2] = idx_reg.out;
                    rdata_next[IDX_CAP_BIT] = idx_reg.cap;
                    rdata_next[IDX_PIN_BIT] = idx_reg.pin;
                end else if (hit(a, OFF_IRQ_STS)) begin
                    rdata_next[IRQ_W-1:0] = sts_reg;
                end else if (hit(a, OFF_IRQ_EN)) begin
                    rdata_next[IRQ_W-1:0] = ien_reg;
                end else if (hit(a, OFF_CAP_STS)) begin
                    rdata_next[7:0] = cnt_reg[idx_reg.cap];
                    rdata_next[B_CAP_RDY] = rdy_reg[idx_reg.cap];
                    rdata_next[B_CAP_OVF] = ovf_reg[idx_reg.cap];
                end
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            aph_reg <= '0;
            wpend_reg <= 1'b0;
            rdata_reg <= RST_WORD;
        end else if (i_clk_en) begin
            aph_reg <= aph_next;
            wpend_reg <= wpend_next;
            rdata_reg <= rdata_next;
        end
    end

    // Unit group: register writes first, then hardware events
    always_comb begin
        logic [11:0] a;
        logic [1:0] po;
        logic we;
        logic edge_seen;
        a = aph_reg.addr;
        po = idx_reg.out;
        we = wpend_reg;
        edge_seen = 1'b0;
        idx_next = idx_reg;
        out_en_next = out_en_reg;
        out_clr_next = out_clr_reg;
        fault_next = fault_reg;
        notify_next = notify_reg;
        fire_q_next = fire;
        tgt_ns_next = tgt_ns_reg;
        tgt_s_next = tgt_s_reg;
        out_src_next = out_src_reg;
        dir_next = dir_reg;
        cap_ie_next = cap_ie_reg;
        cap_on_next = cap_on_reg;
        cap_clr_next = cap_clr_reg;
        rdy_next = rdy_reg;
        ovf_next = ovf_reg;
        cnt_next = cnt_reg;
        sts_next = sts_reg;
        ien_next = ien_reg;

        // Software clear of status; later sets win
        if (we && hit(a, OFF_IRQ_CLR)) begin
            sts_next = sts_reg & ~i_hwdata[IRQ_W-1:0];
        end

        // Register writes to the index, interrupt enable and indexed fields
        if (we) begin
            if (hit(a, OFF_INDEX)) begin
                idx_next.out = i_hwdata[IDX_OUT_LSB +: 2];
                idx_next.cap = i_hwdata[IDX_CAP_BIT];
                idx_next.pin = i_hwdata[IDX_PIN_BIT];
            end else if (hit(a, OFF_IRQ_EN)) begin
                ien_next = i_hwdata[IRQ_W-1:0];
            end else if (hit(a, OFF_UNIT_CTRL)) begin
                out_src_next[idx_reg.pin] = i_hwdata[B_OUT_SRC];
                dir_next[idx_reg.pin] = i_hwdata[B_PIN_DIR];
                cap_ie_next[idx_reg.cap] = i_hwdata[B_CAP_IRQ];
                cap_clr_next[idx_reg.cap] = i_hwdata[B_CAP_CLR];
                cap_on_next[idx_reg.cap] = i_hwdata[B_CAP_ON];
                if (i_hwdata[B_CAP_ON]) begin
                    cnt_next[idx_reg.cap] = RST_CNT;
                end else begin
                    rdy_next[idx_reg.cap] = 1'b0;
                    ovf_next[idx_reg.cap] = 1'b0;
                end
                if (po < 2'(NUM_OUT)) begin
                    out_clr_next[po] = i_hwdata[B_OUT_CLR];
                    out_en_next[po] = i_hwdata[B_OUT_EN];
                    if (!i_hwdata[B_OUT_EN]) begin
                        fault_next[po] = 1'b0;
                    end else if (past[po] && notify_reg[po]) begin
                        fault_next[po] = 1'b1;
                        sts_next[IRQ_FAULT_LSB + 32'(po)] = 1'b1;
                    end
                end
            end else if (po < 2'(NUM_OUT)) begin
                if (hit(a, OFF_TGT_NS)) tgt_ns_next[po] = i_hwdata[29:0];
                if (hit(a, OFF_TGT_S)) tgt_s_next[po] = i_hwdata;
                if (hit(a, OFF_OUT_CFG)) notify_next[po] = i_hwdata[B_NOTIFY];
            end
        end

        // Output units fire and report
        for (int u = 0; u < NUM_OUT; u++) begin
            if (fire[u]) begin
                out_en_next[u] = 1'b0;
                if (notify_reg[u]) sts_next[IRQ_DONE_LSB + u] = 1'b1;
            end
            if (out_clr_next[u]) begin
                out_en_next[u] = 1'b0;
                fault_next[u] = 1'b0;
                notify_next[u] = 1'b0;
                tgt_ns_next[u] = 30'h0000_0000;
                tgt_s_next[u] = RST_WORD;
            end
        end

        // Capture units count rising edges on their own pin
        for (int c = 0; c < NUM_CAP; c++) begin
            edge_seen = pin_s2_reg[c] & ~pin_prev_reg[c] & dir_reg[c] & cap_on_reg[c];
            if (edge_seen) begin
                rdy_next[c] = 1'b1;
                // Count on from the cleared value when an enable write lands too
                if (cnt_next[c] == CNT_MAX) ovf_next[c] = 1'b1;
                else cnt_next[c] = cnt_next[c] + 8'h01;
                if (cap_ie_reg[c]) sts_next[IRQ_CAP_LSB + c] = 1'b1;
            end
            if (cap_clr_next[c]) begin
                cap_on_next[c] = 1'b0;
                cap_ie_next[c] = 1'b0;
                rdy_next[c] = 1'b0;
                ovf_next[c] = 1'b0;
                cnt_next[c] = RST_CNT;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            idx_reg <= '0;
            out_en_reg <= '0;
            out_clr_reg <= '0;
            fault_reg <= '0;
            notify_reg <= '0;
            fire_q_reg <= '0;
            for (int u = 0; u < NUM_OUT; u++) begin
                tgt_ns_reg[u] <= 30'h0000_0000;
                tgt_s_reg[u] <= RST_WORD;
            end
            out_src_reg <= '0;
            dir_reg <= '0;
            cap_ie_reg <= '0;
            cap_on_reg <= '0;
            cap_clr_reg <= '0;
            rdy_reg <= '0;
            ovf_reg <= '0;
            for (int c = 0; c < NUM_CAP; c++) begin
                cnt_reg[c] <= RST_CNT;
            end
            sts_reg <= '0;
            ien_reg <= '0;
        end else if (i_clk_en) begin
            idx_reg <= idx_next;
            out_en_reg <= out_en_next;
            out_clr_reg <= out_clr_next;
            fault_reg <= fault_next;
            notify_reg <= notify_next;
            fire_q_reg <= fire_q_next;
            tgt_ns_reg <= tgt_ns_next;
            tgt_s_reg <= tgt_s_next;
            out_src_reg <= out_src_next;
            dir_reg <= dir_next;
            cap_ie_reg <= cap_ie_next;
            cap_on_reg <= cap_on_next;
            cap_clr_reg <= cap_clr_next;
            rdy_reg <= rdy_next;
            ovf_reg <= ovf_next;
            cnt_reg <= cnt_next;
            sts_reg <= sts_next;
            ien_reg <= ien_next;
        end
    end

    // Pin drive: output unit p on pin p
    generate
        for (genvar p = 0; p < NUM_PIN; p++) begin : g_pin
            assign o_pin_out[p] = out_src_reg[p] ? fire[p] : fire_q_reg[p];
            assign o_pin_oe_n[p] = dir_reg[p];
        end
    endgenerate

    // Bus answers and interrupt
    assign o_hrdata = rdata_reg;
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_irq = |(sts_reg & ien_reg);
endmodule // ppe_top

// file: sim/ppe_assertions.sv
// Purpose: Port-level checks for the pin event control block
// Assumes: One clock domain; bus sampled on rising edges
// Notes: Bound to ppe_top from the bench top file
`timescale 1ns/1ps
module ppe_assertions
    import ppe_pkg::*;
(
    input wire logic i_ref_clk,                   // Clock
    input wire logic i_resetn,                    // Reset, active low
    input wire logic i_clk_en,                    // Clock enable
    input wire logic i_hsel,                      // AHB select
    input wire logic [31:0] i_haddr,              // AHB address
    input wire logic [1:0] i_htrans,              // AHB transfer type
    input wire logic i_hwrite,                    // AHB write
    input wire logic i_hready,                    // AHB ready
    input wire logic [31:0] o_hrdata,             // AHB read data
    input wire logic o_hreadyout,                 // AHB slave ready
    input wire logic o_hresp,                     // AHB response
    input wire logic [NUM_PIN-1:0] o_pin_out,     // Pin levels
    input wire logic [NUM_PIN-1:0] o_pin_oe_n,    // Pin drive enables
    input wire logic o_irq                        // Interrupt
);
    logic acc;
    logic wr_d_reg;
    logic wr_d_next;
    logic ctrl_d_reg;
    logic ctrl_d_next;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_resetn);

    // Accepted address phase and the data-phase flags it leads to
    assign acc = i_hsel & i_htrans[1] & i_hready & i_clk_en;
    always_comb begin
        wr_d_next = acc & i_hwrite;
        ctrl_d_next = acc & i_hwrite & (i_haddr[11:0] == OFF_UNIT_CTRL);
    end
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_d_reg <= 1'h0;
            ctrl_d_reg <= 1'h0;
        end else begin
            wr_d_reg <= wr_d_next;
            ctrl_d_reg <= ctrl_d_next;
        end
    end

    // Read address phases to watch
    sequence s_ns_read;
        acc && !i_hwrite && (i_haddr[11:0] == OFF_TGT_NS);
    endsequence
    sequence s_bad_read;
        acc && !i_hwrite && (i_haddr[11:0] > OFF_CAP_STS);
    endsequence

    ready_always_a: assert property (o_hreadyout == 1'h1)
        else $error("slave ready dropped");
    resp_okay_a: assert property (o_hresp == 1'h0)
        else $error("error response seen");
    rdata_hold_a: assert property ($changed(o_hrdata) |-> $past(acc))
        else $error("read data moved without a request");
    ns_top_zero_a: assert property (s_ns_read |=> o_hrdata[31:30] == 2'h0)
        else $error("ns target top bits not zero");
    unmapped_zero_a: assert property (s_bad_read |=> o_hrdata == 32'h0)
        else $error("unmapped read not zero");
    dir_by_write_a: assert property ($changed(o_pin_oe_n) |-> $past(ctrl_d_reg))
        else $error("pin direction moved without control write");
    pin0_pulse_a: assert property (o_pin_out[0] |=> !o_pin_out[0])
        else $error("pin 0 event longer than one cycle");
    pin1_pulse_a: assert property (o_pin_out[1] |=> !o_pin_out[1])
        else $error("pin 1 event longer than one cycle");
    irq_by_write_a: assert property ($fell(o_irq) |-> $past(wr_d_reg))
        else $error("interrupt dropped without a write");
endmodule // ppe_assertions

// file: sim/tb_top.sv
// Purpose: Self-checking bench for the pin event control block
// Assumes: Zero wait-state slave; bench drives all ports itself
// Notes: One task per scenario; bounded waits end the run on timeout
`timescale 1ns/1ps
module tb_top;
    import ppe_pkg::*;
    logic i_ref_clk;
    logic i_resetn;
    logic i_clk_en;
    logic i_hsel;
    logic [31:0] i_haddr;
    logic [1:0] i_htrans;
    logic i_hwrite;
    logic [31:0] i_hwdata;
    logic [31:0] o_hrdata;
    logic o_hreadyout;
    logic o_hresp;
    logic [31:0] i_sync_sec;
    logic [29:0] i_sync_ns;
    logic [NUM_PIN-1:0] i_pin_in;
    logic [NUM_PIN-1:0] o_pin_out;
    logic [NUM_PIN-1:0] o_pin_oe_n;
    logic o_irq;
    logic [31:0] rd;
    int failures;
    int comparisons;

    ppe_top u_ppe_top (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_clk_en(i_clk_en),
        .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
        .i_hsize(3'h2), .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hrdata(o_hrdata),
        .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_sync_sec(i_sync_sec),
        .i_sync_ns(i_sync_ns), .i_pin_in(i_pin_in), .o_pin_out(o_pin_out),
        .o_pin_oe_n(o_pin_oe_n), .o_irq(o_irq));

    // Clock, 40 ns period
    initial begin
        i_ref_clk = 1'h0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end

    task automatic give_verdict();
        $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Waits for ready under a bound
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (o_hreadyout !== 1'h1 && n < 64);
        if (o_hreadyout !== 1'h1) begin
            failures++;
            $display("wrong value at %0t: bus wait ran out", $time);
            give_verdict();
        end
    endtask

    // One single AHB transfer; read data taken at the data-phase edge
    task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] wd);
        @(posedge i_ref_clk);
        i_hsel <= 1'h1;
        i_htrans <= 2'h2;
        i_haddr <= {20'h00000, a};
        i_hwrite <= w;
        wait_ready();
        i_hsel <= 1'h0;
        i_htrans <= 2'h0;
        i_hwdata <= wd;
        wait_ready();
        rd = o_hrdata;
        #1;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(a, 1'h1, d);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string what);
        bus(a, 1'h0, 32'h0);
        check(rd, exp, what);
    endtask

    function automatic logic [31:0] bv(input int b);
        return 32'h00000001 << b;
    endfunction

    task automatic set_idx(input logic [1:0] o, input logic c, input logic p);
        wr(OFF_INDEX, {15'h0000, p, 7'h00, c, 6'h00, o});
    endtask

    // Pin change, then enough edges to pass the synchroniser
    task automatic pin_step(input int p, input logic v);
        @(posedge i_ref_clk);
        i_pin_in[p] <= v;
        repeat (4) @(posedge i_ref_clk);
    endtask

    task automatic t_reset();
        check({30'h0, o_pin_oe_n}, 32'h0, "pins drive after reset");
        rdc(OFF_UNIT_CTRL, RST_WORD, "control reset");
        rdc(OFF_TGT_NS, RST_WORD, "ns reset");
        rdc(OFF_TGT_S, RST_WORD, "sec reset");
        wr(12'h5FC, 32'hFFFFFFFF);
        rdc(12'h5FC, 32'h0, "unmapped read");
        $display("test reset done");
    endtask

    task automatic t_targets();
        set_idx(2'h1, 1'h0, 1'h0);
        wr(OFF_TGT_NS, 32'hFFFFFFFF);
        wr(OFF_TGT_S, 32'hA5A5A5A5);
        set_idx(2'h0, 1'h0, 1'h0);
        rdc(OFF_TGT_NS, 32'h0, "other unit untouched");
        set_idx(2'h1, 1'h0, 1'h0);
        rdc(OFF_TGT_NS, 32'h3FFFFFFF, "ns width");
        rdc(OFF_TGT_S, 32'hA5A5A5A5, "sec width");
        @(posedge i_ref_clk);
        i_clk_en <= 1'h0;
        wr(OFF_TGT_S, 32'h00000001);
        @(posedge i_ref_clk);
        i_clk_en <= 1'h1;
        rdc(OFF_TGT_S, 32'hA5A5A5A5, "frozen write ignored");
        set_idx(2'h3, 1'h0, 1'h0);
        wr(OFF_TGT_S, 32'h12345678);
        rdc(OFF_TGT_S, 32'h0, "pointer three");
        $display("test targets done");
    endtask

    // Comb and registered drive; notify on for the first pass only
    task automatic t_fire();
        logic src;
        logic [31:0] sb;
        wr(OFF_IRQ_EN, 32'h000000FF);
        for (int i = 0; i < 2; i++) begin
            src = i[0];
            sb = src ? bv(B_OUT_SRC) : 32'h0;
            set_idx(2'h0, 1'h0, 1'h0);
            wr(OFF_OUT_CFG, src ? 32'h0 : bv(B_NOTIFY));
            wr(OFF_TGT_NS, 32'h000003E8);
            wr(OFF_TGT_S, 32'h00000005);
            @(posedge i_ref_clk);
            i_sync_sec <= 32'h00000005;
            i_sync_ns <= 30'h000003E7;
            wr(OFF_UNIT_CTRL, bv(B_OUT_EN) | sb);
            rdc(OFF_UNIT_CTRL, bv(B_OUT_EN) | bv(B_OUT_ACT) | sb, "armed");
            check({30'h0, o_pin_out}, 32'h0, "no fire before target");
            @(posedge i_ref_clk);
            i_sync_ns <= 30'h000003E8;
            #1;
            check({31'h0, o_pin_out[0]}, {31'h0, src}, "fire this cycle");
            @(posedge i_ref_clk);
            #1;
            check({31'h0, o_pin_out[0]}, {31'h0, ~src}, "fire next cycle");
            rdc(OFF_UNIT_CTRL, sb, "enable self-cleared");
            rdc(OFF_IRQ_STS, src ? 32'h0 : bv(IRQ_DONE_LSB), "done status");
            check({31'h0, o_irq}, {31'h0, ~src}, "irq level");
            wr(OFF_IRQ_EN, 32'h0);
            check({31'h0, o_irq}, 32'h0, "irq masked");
            wr(OFF_IRQ_EN, 32'h000000FF);
            wr(OFF_IRQ_CLR, 32'h000000FF);
            check({31'h0, o_irq}, 32'h0, "irq cleared");
        end
        $display("test fire done");
    endtask

    task automatic t_fault();
        set_idx(2'h1, 1'h0, 1'h0);
        wr(OFF_OUT_CFG, bv(B_NOTIFY));
        wr(OFF_TGT_S, 32'h00000001);
        @(posedge i_ref_clk);
        i_sync_sec <= 32'h00000009;
        wr(OFF_UNIT_CTRL, bv(B_OUT_EN));
        rdc(OFF_UNIT_CTRL, bv(B_OUT_EN), "past target inactive");
        rdc(OFF_IRQ_STS, bv(IRQ_FAULT_LSB + 1), "fault status");
        check({31'h0, o_pin_out[1]}, 32'h0, "no fire on fault");
        wr(OFF_UNIT_CTRL, 32'h0);
        wr(OFF_IRQ_CLR, 32'h000000FF);
        $display("test fault done");
    endtask

    task automatic t_soft();
        set_idx(2'h2, 1'h0, 1'h0);
        wr(OFF_TGT_S, 32'hFFFFFFFF);
        wr(OFF_UNIT_CTRL, bv(B_OUT_EN));
        rdc(OFF_UNIT_CTRL, bv(B_OUT_EN) | bv(B_OUT_ACT), "running");
        wr(OFF_UNIT_CTRL, bv(B_OUT_CLR) | bv(B_OUT_EN));
        rdc(OFF_UNIT_CTRL, bv(B_OUT_CLR), "held inactive");
        rdc(OFF_TGT_S, 32'h0, "default target");
        wr(OFF_UNIT_CTRL, 32'h0);
        rdc(OFF_UNIT_CTRL, 32'h0, "normal again");
        $display("test soft clear done");
    endtask

    task automatic t_capture();
        logic [31:0] w;
        w = bv(B_PIN_DIR) | bv(B_CAP_IRQ) | bv(B_CAP_ON);
        set_idx(2'h3, 1'h1, 1'h1);
        wr(OFF_UNIT_CTRL, w);
        check({30'h0, o_pin_oe_n}, 32'h00000002, "pin 1 input");
        pin_step(1, 1'h1);
        rdc(OFF_CAP_STS, bv(B_CAP_RDY) | 32'h1, "first capture");
        rdc(OFF_UNIT_CTRL, w | bv(B_PIN_LVL), "level high");
        rdc(OFF_IRQ_STS, bv(IRQ_CAP_LSB + 1), "capture status");
        pin_step(1, 1'h0);
        pin_step(1, 1'h1);
        wr(OFF_UNIT_CTRL, w & ~bv(B_CAP_ON));
        rdc(OFF_CAP_STS, 32'h00000002, "off clears ready");
        wr(OFF_UNIT_CTRL, w);
        rdc(OFF_CAP_STS, 32'h0, "on clears count");
        wr(OFF_IRQ_CLR, 32'h000000FF);
        wr(OFF_UNIT_CTRL, w & ~bv(B_CAP_IRQ));
        pin_step(1, 1'h0);
        pin_step(1, 1'h1);
        rdc(OFF_IRQ_STS, 32'h0, "capture irq gated");
        rdc(OFF_CAP_STS, bv(B_CAP_RDY) | 32'h1, "counted");
        wr(OFF_UNIT_CTRL, w | bv(B_CAP_CLR));
        rdc(OFF_CAP_STS, 32'h0, "soft clear defaults");
        pin_step(1, 1'h0);
        rdc(OFF_UNIT_CTRL, bv(B_PIN_DIR) | bv(B_CAP_CLR), "level low held");
        wr(OFF_UNIT_CTRL, w);
        for (int k = 0; k < 256; k++) begin
            pin_step(1, 1'h1);
            pin_step(1, 1'h0);
        end
        rdc(OFF_CAP_STS, bv(B_CAP_OVF) | bv(B_CAP_RDY) | 32'hFF, "count saturates");
        wr(OFF_UNIT_CTRL, w & ~bv(B_CAP_ON));
        rdc(OFF_CAP_STS, 32'h000000FF, "off clears overflow");
        $display("test capture done");
    endtask

    // Reset, then the scenarios
    initial begin
        failures = 0;
        comparisons = 0;
        i_resetn = 1'h0;
        i_clk_en = 1'h1;
        i_hsel = 1'h0;
        i_haddr = 32'h0;
        i_htrans = 2'h0;
        i_hwrite = 1'h0;
        i_hwdata = 32'h0;
        i_sync_sec = 32'h0;
        i_sync_ns = 30'h0;
        i_pin_in = 2'h0;
        repeat (12) @(posedge i_ref_clk);
        i_resetn <= 1'h1;
        t_reset();
        t_targets();
        t_fire();
        t_fault();
        t_soft();
        t_capture();
        give_verdict();
    end
endmodule // tb_top

bind ppe_top ppe_assertions u_ppe_assertions (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
    .i_clk_en(i_clk_en), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_pin_out(o_pin_out),
    .o_pin_oe_n(o_pin_oe_n), .o_irq(o_irq));
